// >>> responder_pkg.sv
// Purpose: shared constants and types for the logger bus data responder
// Assumes: 32-bit measurement words, axi4-lite register access
// Notes:   offsets are byte addresses of aligned words
package responder_pkg;
  localparam logic [4:0]  addr_max         = 5'h0e;
  localparam logic [2:0]  code_trigger     = 3'h7;
  localparam logic [7:0]  off_ctrl         = 8'h00;
  localparam logic [7:0]  off_status       = 8'h04;
  localparam logic [7:0]  off_irq_stat     = 8'h08;
  localparam logic [7:0]  off_irq_clr      = 8'h0c;
  localparam logic [7:0]  off_irq_en       = 8'h10;
  localparam logic [7:0]  off_health       = 8'h14;
  localparam logic [7:0]  off_meas_base    = 8'h40;
  localparam int          ctrl_addr_lsb    = 0;
  localparam int          ctrl_en_bit      = 8;
  localparam logic [31:0] ctrl_reset       = 32'h0000_0000;
  localparam int          irq_trig_bit     = 0;
  localparam int          irq_done_bit     = 1;
  localparam int          irq_bad_bit      = 2;
  localparam int          n_items          = 11;
  localparam int          max_words        = 11;
  localparam logic [1:0]  resp_okay        = 2'b00;
  localparam logic [1:0]  resp_slverr      = 2'b10;

  // item indices in the measurement table
  typedef enum logic [3:0] {
    it_co2_dens, it_h2o_dens, it_co2_abs, it_h2o_abs, it_press, it_temp,
    it_aux1, it_cooler, it_health, it_bandwidth, it_delay
  } item_type;

  typedef struct packed {
    logic       chopper_ok;
    logic       detector_ok;
    logic       phase_lock_ok;
    logic       sync_ok;
    logic [3:0] gain_control_level;
  } health_type;

  typedef struct packed {
    logic       sel;
    logic [2:0] item_set_code;
    logic       trigger;
  } bus_cmd_type;
endpackage : responder_pkg

// >>> logger_bus_data_responder.sv
// Purpose: respond on the logger serial bus with measurement word sets
// Assumes: the bus front end decodes select, code and trigger per frame
// Notes:   software loads measurement words and sets the address over axi4-lite
`timescale 1ns/100ps
`default_nettype none

// What this block does
// (RQ1) answer only the software-set bus address, limited to 0 through 14
// (RQ2) codes 0 to 6 return the item set belonging to that code
// (RQ3) code 7 is accepted as group-triggered mode
// (RQ4) codes 0 to 3 return density, absorptance, pressure group, health group
// (RQ5) code 4 concatenates codes 0-3; code 5 and 6 as listed
// (RQ6) code 7 captures co2, h2o, gain control level, pressure on each trigger, holds
// (RQ7) datalogger broadcasts group trigger before each code 7 read
// (RQ8) serial words shift out least significant bit first
// (RQ9) health byte bits 7..4 flag chopper, detector, phase lock, sync ok
// (RQ10) health bits 3..0 carry the gain control level count
// (RQ11) words of one response to codes 0 to 6 come from one snapshot of measurements
module logger_bus_data_responder
  import responder_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cmd_valid,
  input  wire logic [3:0]  cmd_address,
  input  wire logic [2:0]  cmd_code,
  input  wire logic        group_trigger,
  input  wire logic        bit_enable,
  input  wire health_type  health_in,
  output var  logic        tx_bit,
  output var  logic        tx_active,
  output var  logic        irq
);
  typedef enum {st_idle, st_shift} tx_state_type;

  logic [31:0] meas_q [n_items];
  logic [31:0] snap_q [n_items];
  logic [31:0] trig_q [4];
  logic [31:0] ctrl_q, ctrl_d;
  logic [2:0]  irq_stat_q, irq_stat_d, irq_en_q, irq_en_d;
  logic        aw_q, w_q, bvalid_q, rvalid_q;
  logic [31:0] awaddr_q, wdata_q, rdata_q;
  logic [1:0]  bresp_q, rresp_q;
  tx_state_type st_q, st_d;
  logic [3:0]  word_q, word_d, nwords_q, nwords_d;
  logic [4:0]  bit_q, bit_d;
  logic [2:0]  code_q, code_d;
  logic [31:0] shreg_q, shreg_d;
  logic        tx_bit_q, tx_bit_d, irq_q;
  logic        wr_go, hit, bad, trig_ev, done_ev;
  logic [3:0]  item;
  logic [31:0] health_word;
  logic [31:0] next_word, cur_word;

  assign health_word = {24'h00_0000, health_in};  // see (RQ9) see (RQ10)
  assign wr_go = aw_q && w_q && !bvalid_q;
  // address field is clamped at 14; 15 never matches
  assign hit = cmd_valid && ctrl_q[ctrl_en_bit] && st_q == st_idle &&
               {1'b0, cmd_address} == ctrl_q[ctrl_addr_lsb +: 5] &&
               ctrl_q[ctrl_addr_lsb +: 5] <= addr_max;  // see (RQ1)
  assign bad = 1'b0;
  assign trig_ev = group_trigger && ctrl_q[ctrl_en_bit];
  assign done_ev = st_q == st_shift && bit_enable && bit_q == 5'd31 &&
                   word_q == nwords_q - 4'd1;

  function automatic logic [3:0] set_len(input logic [2:0] c);
    case (c)
      3'd0, 3'd1: set_len = 4'd2;
      3'd2, 3'd6, 3'd7: set_len = 4'd4;
      3'd3, 3'd5: set_len = 4'd3;
      default: set_len = 4'd11;
    endcase
  endfunction : set_len

  // see (RQ2) see (RQ4) see (RQ5)
  always_comb begin
    item = 4'(it_co2_dens);
    case (code_q)
      3'd0: item = word_q;
      3'd1: item = 4'(it_co2_abs) + word_q;
      3'd2: item = 4'(it_press) + word_q;
      3'd3: item = 4'(it_health) + word_q;
      3'd4: item = word_q;
      3'd5, 3'd6: item = (word_q < 4'd2) ? word_q :
                         (word_q == 4'd2) ? 4'(it_press) : 4'(it_health);
      default: item = word_q;
    endcase
  end

  // axi write and read channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0; w_q <= 1'b0; bvalid_q <= 1'b0; rvalid_q <= 1'b0;
      awaddr_q <= 32'h0000_0000; wdata_q <= 32'h0000_0000;
      rdata_q <= 32'h0000_0000; bresp_q <= resp_okay; rresp_q <= resp_okay;
    end else begin
      if (s_axi_awvalid && !aw_q) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= (awaddr_q[7:0] == off_ctrl || awaddr_q[7:0] == off_irq_clr ||
                    awaddr_q[7:0] == off_irq_en ||
                    (awaddr_q[7:0] >= off_meas_base &&
                     awaddr_q[7:0] < off_meas_base + 8'(4 * n_items)))
                   ? resp_okay : resp_slverr;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        aw_q <= 1'b0;
        w_q <= 1'b0;
      end
      if (s_axi_arvalid && !rvalid_q) begin
        rvalid_q <= 1'b1;
        rresp_q <= resp_okay;
        case (s_axi_araddr[7:0])
          off_ctrl:     rdata_q <= ctrl_q;
          off_status:   rdata_q <= {27'h000_0000, tx_active, code_q, st_q == st_shift};
          off_irq_stat: rdata_q <= {29'h0000_0000, irq_stat_q};
          off_irq_en:   rdata_q <= {29'h0000_0000, irq_en_q};
          off_health:   rdata_q <= health_word;
          default: begin
            if (s_axi_araddr[7:0] >= off_meas_base &&
                s_axi_araddr[7:0] < off_meas_base + 8'(4 * n_items))
              rdata_q <= meas_q[4'((s_axi_araddr[7:0] - off_meas_base) >> 2)];
            else begin
              rdata_q <= 32'h0000_0000;
              rresp_q <= resp_slverr;
            end
          end
        endcase
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // software registers; event set wins over clear
  always_comb begin
    ctrl_d = ctrl_q;
    irq_en_d = irq_en_q;
    irq_stat_d = irq_stat_q;
    if (wr_go && awaddr_q[7:0] == off_ctrl) begin
      ctrl_d = wdata_q;
      if (wdata_q[ctrl_addr_lsb +: 5] > addr_max)
        ctrl_d[ctrl_addr_lsb +: 5] = addr_max;  // see (RQ1)
    end
    if (wr_go && awaddr_q[7:0] == off_irq_en) irq_en_d = wdata_q[2:0];
    if (wr_go && awaddr_q[7:0] == off_irq_clr) irq_stat_d = irq_stat_q & ~wdata_q[2:0];
    if (trig_ev) irq_stat_d[irq_trig_bit] = 1'b1;
    if (done_ev) irq_stat_d[irq_done_bit] = 1'b1;
    if (bad) irq_stat_d[irq_bad_bit] = 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= ctrl_reset;
      irq_en_q <= 3'h0;
      irq_stat_q <= 3'h0;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      irq_en_q <= irq_en_d;
      irq_stat_q <= irq_stat_d;
      irq_q <= |(irq_stat_d & irq_en_d);
    end
  end

  // measurement table, snapshot and trigger capture
  always_ff @(posedge aclk) begin
    for (int i = 0; i < n_items; i++) begin
      if (!aresetn)
        meas_q[i] <= 32'h0000_0000;
      else if (wr_go && awaddr_q[7:0] == off_meas_base + 8'(4 * i))
        meas_q[i] <= wdata_q;
      else if (i == int'(it_health))
        meas_q[i] <= health_word;
    end
    for (int i = 0; i < n_items; i++) begin
      if (!aresetn)
        snap_q[i] <= 32'h0000_0000;
      else if (hit)
        snap_q[i] <= meas_q[i];  // see (RQ11)
    end
    for (int i = 0; i < 4; i++) begin
      if (!aresetn)
        trig_q[i] <= 32'h0000_0000;
      else if (trig_ev) begin  // see (RQ6) see (RQ7)
        case (i)
          0: trig_q[i] <= meas_q[it_co2_dens];
          1: trig_q[i] <= meas_q[it_h2o_dens];
          2: trig_q[i] <= {28'h000_0000, health_in.gain_control_level};
          default: trig_q[i] <= meas_q[it_press];
        endcase
      end
    end
  end

  // serial shifter
  always_comb begin
    st_d = st_q;
    word_d = word_q;
    bit_d = bit_q;
    code_d = code_q;
    nwords_d = nwords_q;
    shreg_d = shreg_q;
    tx_bit_d = tx_bit_q;
    cur_word = shreg_q;
    case (st_q)
      st_idle: begin
        if (hit) begin
          st_d = st_shift;
          code_d = cmd_code;  // see (RQ3)
          nwords_d = set_len(cmd_code);
          word_d = 4'd0;
          bit_d = 5'd0;
          // other codes load each word from the snapshot at its first bit
          shreg_d = trig_q[0];
        end
      end
      st_shift: begin
        if (bit_enable) begin
          cur_word = (bit_q == 5'd0 && code_q != code_trigger) ? next_word : shreg_q;
          tx_bit_d = cur_word[0];  // see (RQ8)
          shreg_d = {1'b0, cur_word[31:1]};
          bit_d = bit_q + 5'd1;
          if (bit_q == 5'd31) begin
            word_d = word_q + 4'd1;
            if (done_ev) st_d = st_idle;
            else if (code_q == code_trigger) shreg_d = trig_q[word_q[1:0] + 2'd1];
          end
        end
      end
      default: st_d = st_idle;
    endcase
  end

  // snapshot reload for non-trigger words follows the item map
  assign next_word = snap_q[item];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= st_idle;
      word_q <= 4'd0;
      bit_q <= 5'd0;
      code_q <= 3'd0;
      nwords_q <= 4'd0;
      shreg_q <= 32'h0000_0000;
      tx_bit_q <= 1'b0;
    end else begin
      st_q <= st_d;
      word_q <= word_d;
      bit_q <= bit_d;
      code_q <= code_d;
      nwords_q <= nwords_d;
      tx_bit_q <= tx_bit_d;
      shreg_q <= shreg_d;
    end
  end

  assign s_axi_awready = !aw_q;
  assign s_axi_wready  = !w_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign tx_bit        = tx_bit_q;
  assign tx_active     = st_q == st_shift;
  assign irq           = irq_q;

  a_addr_clamped: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_q[4:0] <= addr_max) else $error("address above 14");  // see (RQ1)
  a_trig_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !trig_ev |=> trig_q[0] == $past(trig_q[0])) else $error("trigger set moved");  // see (RQ6)
  a_no_foreign: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == st_idle && cmd_valid && {1'b0, cmd_address} != ctrl_q[4:0] |=> st_q == st_idle)
    else $error("answered foreign address");  // see (RQ1)
  a_health_map: assert property (@(posedge aclk) disable iff (!aresetn)
    health_word[7] == health_in.chopper_ok && health_word[3:0] == health_in.gain_control_level)
    else $error("health byte map wrong");  // see (RQ9)
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 irq == |($past(irq_stat_d) & $past(irq_en_d))) else $error("irq mismatch");
  a_len_code4: assert property (@(posedge aclk) disable iff (!aresetn)
    hit && cmd_code == 3'd4 |=> nwords_q == 4'd11) else $error("code 4 length");  // see (RQ5)
  a_len_code0: assert property (@(posedge aclk) disable iff (!aresetn)
    hit && cmd_code == 3'd0 |=> nwords_q == 4'd2) else $error("code 0 length");  // see (RQ4)
  a_lsb_first: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == st_shift && bit_enable && bit_q != 5'd0 |=> tx_bit_q == $past(shreg_q[0]))
    else $error("bit order wrong");  // see (RQ8)
  c_code7: cover property (@(posedge aclk) hit && cmd_code == code_trigger);
  c_code4: cover property (@(posedge aclk) hit && cmd_code == 3'd4);
  c_done:  cover property (@(posedge aclk) done_ev);
endmodule : logger_bus_data_responder
`default_nettype wire

// >>> logger_master_model.sv
// Purpose: datalogger model driving requests and triggers on the logger serial bus
// Assumes: one serial bit time is a one-cycle bit_enable pulse
// Notes:   released request lines show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module logger_master_model (
  input  wire logic       aclk,
  input  wire logic       tx_bit,
  input  wire logic       tx_active,
  output var  logic       cmd_valid,
  output var  logic [3:0] cmd_address,
  output var  logic [2:0] cmd_code,
  output var  logic       group_trigger,
  output var  logic       bit_enable
);
  logic [31:0] rx [0:10];
  int          got;
  initial begin
    cmd_valid = 1'b0;
    cmd_address = 4'h0;
    cmd_code = 3'h0;
    group_trigger = 1'b0;
    bit_enable = 1'b0;
  end
  // broadcast that freshens the code 7 set before its read
  task trig;
    group_trigger <= 1'b1;
    @(posedge aclk);
    group_trigger <= 1'b0;
  endtask : trig
  // only codes 0 to 7 are ever requested
  task request(input logic [3:0] a, input logic [2:0] c, input int n);
    int w;
    w = 0;
    got = 0;
    cmd_valid <= 1'b1;
    cmd_address <= a;
    cmd_code <= c;
    @(posedge aclk);
    cmd_valid <= 1'b0;
    cmd_address <= ~a;
    cmd_code <= ~c;
    while (!tx_active && w < 4) begin
      @(posedge aclk);
      w++;
    end
    if (!tx_active) return;
    // words assembled least significant bit first
    // tx_bit is launched at the edge that takes bit_enable, so read it one edge later
    for (int b = 0; b < 32 * n; b++) begin
      bit_enable <= 1'b1;
      @(posedge aclk);
      bit_enable <= 1'b0;
      @(posedge aclk);
      rx[b / 32][b % 32] = tx_bit;
    end
    got = n;
  endtask : request
endmodule : logger_master_model
`default_nettype wire

// >>> tb_logger_bus_data_responder.sv
// Purpose: self-checking bench for the logger bus data responder
// Assumes: axi4-lite master tasks, datalogger model on the serial side
// Notes:   health word judged on all 32 bits, upper bits expected zero
`timescale 1ns/100ps
`default_nettype none
module tb_logger_bus_data_responder;
  import responder_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, tx_bit, tx_active;
  logic [1:0]  bresp, rresp;
  logic        cmd_valid, group_trigger, bit_enable;
  logic [3:0]  cmd_address;
  logic [2:0]  cmd_code;
  health_type  health = 8'h7d;
  int          errors = 0;
  int          tests_run = 0;
  // item order per code, low nibble first, f ends the list
  localparam logic [47:0] sets [0:6] = '{48'hFFFF_FFFF_FF10, 48'hFFFF_FFFF_FF32,
    48'hFFFF_FFFF_7654, 48'hFFFF_FFFF_FA98, 48'hFA98_7654_3210,
    48'hFFFF_FFFF_F410, 48'hFFFF_FFFF_8410};
  always #5 aclk = ~aclk;
  logger_bus_data_responder i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cmd_valid(cmd_valid), .cmd_address(cmd_address), .cmd_code(cmd_code),
    .group_trigger(group_trigger), .bit_enable(bit_enable), .health_in(health),
    .tx_bit(tx_bit), .tx_active(tx_active), .irq(irq));
  logger_master_model i_far (.aclk(aclk), .tx_bit(tx_bit), .tx_active(tx_active),
    .cmd_valid(cmd_valid), .cmd_address(cmd_address), .cmd_code(cmd_code),
    .group_trigger(group_trigger), .bit_enable(bit_enable));
  function automatic logic [31:0] mv(input logic [3:0] i);
    // bit 0 set so a lost or stale first bit shows up
    return {16'hC0DE, 4'h0, i, 8'ha5};
  endfunction : mv
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task axw(input logic [7:0] a, input logic [31:0] d);
    awaddr <= {24'h00_0000, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axw
  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= {24'h00_0000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axr
  task set_check(input logic [2:0] c);
    int n;
    logic [3:0] it;
    n = 0;
    while (n < 11 && sets[c][4 * n +: 4] != 4'hf) n++;
    i_far.request(4'h3, c, n);
    check("word count", i_far.got, n);
    for (int k = 0; k < n; k++) begin
      it = sets[c][4 * k +: 4];
      if (it == 4'h8) check("health", i_far.rx[k], {24'h00_0000, health});
      else check("item", i_far.rx[k], mv(it));
    end
  endtask : set_check
  task t_codes;
    for (int c = 0; c < 7; c++) set_check(3'(c));
  endtask : t_codes
  task t_addr;
    logic [31:0] d;
    logic [1:0]  r;
    i_far.request(4'h4, 3'h0, 2);
    check("foreign address", i_far.got, 0);
    axw(off_ctrl, 32'h0000_011F);
    axr(off_ctrl, d, r);
    check("address clamp", {27'h0, d[4:0]}, {27'h0, addr_max});
    i_far.request(4'he, 3'h0, 2);
    check("top address", i_far.got, 2);
    i_far.request(4'hf, 3'h0, 2);
    check("address 15", i_far.got, 0);
    axw(off_ctrl, 32'h0000_0103);
    axr(8'h30, d, r);
    check("unmapped resp", {30'h0, r}, {30'h0, resp_slverr});
    check("unmapped data", d, 32'h0000_0000);
  endtask : t_addr
  task t_trig;
    logic [31:0] d;
    logic [1:0]  r;
    axw(off_irq_en, 32'h0000_0001);
    i_far.trig();
    repeat (3) @(posedge aclk);
    check("irq raised", {31'h0, irq}, 32'h0000_0001);
    axw(off_meas_base, 32'h1234_5678);
    i_far.request(4'h3, code_trigger, 4);
    check("held co2", i_far.rx[0], mv(4'h0));
    check("held h2o", i_far.rx[1], mv(4'h1));
    check("held gain", i_far.rx[2], 32'h0000_000D);
    check("held press", i_far.rx[3], mv(4'h4));
    axr(off_irq_stat, d, r);
    check("trigger status", {31'h0, d[irq_trig_bit]}, 32'h0000_0001);
    axw(off_irq_clr, 32'h0000_0001);
    repeat (3) @(posedge aclk);
    check("irq cleared", {31'h0, irq}, 32'h0000_0000);
    i_far.trig();
    i_far.request(4'h3, code_trigger, 4);
    check("fresh co2", i_far.rx[0], 32'h1234_5678);
  endtask : t_trig
  task results;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  // the run needs some 2700 cycles; the limit leaves wide room
  initial begin
    #300us;
    errors++;
    results();
  end
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(off_ctrl, d, r);
    check("ctrl reset", d, ctrl_reset);
    for (int i = 0; i < n_items; i++) axw(off_meas_base + 8'(4 * i), mv(4'(i)));
    axw(off_ctrl, 32'h0000_0103);
    t_codes();
    t_addr();
    t_trig();
    results();
  end
endmodule : tb_logger_bus_data_responder
`default_nettype wire
